// ### pkg/rbsd_defs.vh
`ifndef RBSD_DEFS_VH
`define RBSD_DEFS_VH

// Host address map
`define RBSD_IO_BASE 16'h7800
`define RBSD_ADAPTER_ADDR 16'h7a00
`define RBSD_SWITCH_ADDR 16'h7c00
`define RBSD_BANK_SEL_ADDR 16'h7e00
`define RBSD_BANK_WIN_BASE 16'h8000
`define RBSD_BANK_WIN_LAST 16'hbfff
`define RBSD_SYS_ROM_BASE 16'hc000

// I/O sub-decoder codes on address bits 10:8
`define RBSD_IO_CODE_ADAPTER 3'h2
`define RBSD_IO_CODE_SWITCH 3'h4
`define RBSD_IO_CODE_BANK 3'h6

// Bank-select latch field positions
`define RBSD_BIT_HALF 0
`define RBSD_BIT_CE_LO 1
`define RBSD_BIT_CE_HI 3
`define RBSD_BIT_HIGH_BANK 4

// Reset value of the bank latch: bank 0
`define RBSD_BANK_SEL_RESET 8'h00

`endif

// ### src/rbsd_sync2.v
`timescale 1ns/10ps
`default_nettype none
module rbsd_sync2 #(
  parameter W = 1
) (
  input wire clk_sys,
  input wire rstn,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      meta <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // rbsd_sync2
`default_nettype wire

// ### src/rbsd_ce_decoder.v
`timescale 1ns/10ps
`default_nettype none
// Three-to-eight active-low decoder with an active-high enable
module rbsd_ce_decoder (
  input wire enable,
  input wire [2:0] sel,
  output wire [7:0] ce_n
);
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_ce
      localparam [2:0] IDX = i;
      assign ce_n[i] = ~(enable && (sel == IDX)); // RULE_06
    end
  endgenerate
endmodule // rbsd_ce_decoder
`default_nettype wire

// ### src/rbsd_rom_bank_select_decoder.v
`timescale 1ns/10ps
`default_nettype none
`include "rbsd_defs.vh"
// Function
// RULE_01: System ROM region always mapped
// RULE_02: One ROM for both halves, A14 picks
// RULE_03: Bank-select write latches data byte
// RULE_04: D4 picks seventeenth bank or decoder
// RULE_05: D0 drives ROM top address line
// RULE_06: D1-D3 decode eight gated chip enables
// RULE_07: Enable index bank/2, D0 bank mod 2
// RULE_08: Bank 0/1 ROM needs window and enable
// RULE_09: Bank held until next host write
// RULE_10: Phi2-qualified I/O decode on A8-A10
// RULE_11: Switch read returns rear switches
// RULE_12: Adapter select; interrupt pulls request low
// RULE_13: Second latch copy holds D0, D4
// RULE_14: Seventeen 16K banks, two per ROM
// RULE_15: Chip enables exposed as indicators
// RULE_16: I/O select for 7800-7FFF
// RULE_17: Reset clears bank latch to zero
module rbsd_rom_bank_select_decoder (
  input wire clk_sys,
  input wire rstn,
  input wire [15:0] host_addr,
  input wire [7:0] host_wdata,
  input wire host_wr_n,
  input wire phi2,
  output reg [7:0] host_rdata,
  output wire host_rdata_oe_n,
  input wire [7:0] rear_switches,
  input wire adapter_irq,
  output wire service_req_o,
  output wire service_req_oe_n,
  output wire bus_interface_adapter_sel_n,
  output wire switch_sel_n,
  output wire bank_strobe_n,
  output wire [7:0] rom_chip_enables,
  output wire [7:0] diag_leds_n,
  output wire low_rom_chip_enable,
  output wire rom_high_addr,
  output wire sys_rom_ce_n,
  output wire sys_rom_a14,
  output wire bank_rom_ce_n
);
  // Bus signals come from another clock (phi2); resynchronise all of them
  wire [15:0] addr_s;
  wire [7:0] wdata_s;
  wire [7:0] sw_s;
  wire wr_n_s;
  wire phi2_s;
  wire irq_s;
  reg phi2_d;
  reg [7:0] bank_sel;
  reg [1:0] bank_copy;

  rbsd_sync2 #(.W(16)) u_sync_addr (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d(host_addr),
    .q(addr_s)
  );
  rbsd_sync2 #(.W(8)) u_sync_wdata (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d(host_wdata),
    .q(wdata_s)
  );
  rbsd_sync2 #(.W(8)) u_sync_sw (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d(rear_switches),
    .q(sw_s)
  );
  rbsd_sync2 #(.W(3)) u_sync_ctl (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d({host_wr_n, phi2, adapter_irq}),
    .q({wr_n_s, phi2_s, irq_s})
  );

  // Decoded I/O select for the 7800-7FFF I/O page
  wire [15:0] io_base = `RBSD_IO_BASE;
  wire [15:0] win_base = `RBSD_BANK_WIN_BASE;
  wire [15:0] sys_base = `RBSD_SYS_ROM_BASE;
  wire io_space = (addr_s[15:11] == io_base[15:11]); // RULE_16
  wire io_qual = io_space && phi2_s; // RULE_10
  wire [2:0] io_code = addr_s[10:8];
  wire sel_adapter = io_qual && (io_code == `RBSD_IO_CODE_ADAPTER); // RULE_10
  wire sel_switch = io_qual && (io_code == `RBSD_IO_CODE_SWITCH); // RULE_10
  wire sel_bank = io_qual && (io_code == `RBSD_IO_CODE_BANK); // RULE_10

  assign bus_interface_adapter_sel_n = ~sel_adapter; // RULE_12
  assign switch_sel_n = ~sel_switch;
  assign bank_strobe_n = ~(sel_bank && !wr_n_s);

  // Interrupt is open-drain: drive low only while asserted
  assign service_req_o = 1'b0; // RULE_12
  assign service_req_oe_n = ~irq_s; // RULE_12

  // Latch on the falling phi2 edge so data has settled through the write
  // Decode without phi2 here: synced phi2 is already low on the load edge
  wire bank_addr = io_space && (io_code == `RBSD_IO_CODE_BANK);
  wire bank_write = bank_addr && !wr_n_s && phi2_d && !phi2_s; // RULE_13

  always @(posedge clk_sys) begin
    if (!rstn) begin
      phi2_d <= 1'b0;
    end else begin
      phi2_d <= phi2_s;
    end
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      bank_sel <= `RBSD_BANK_SEL_RESET; // RULE_17
      bank_copy <= 2'b00; // RULE_17
    end else if (bank_write) begin
      bank_sel <= wdata_s; // RULE_03 RULE_09
      bank_copy <= {wdata_s[`RBSD_BIT_HIGH_BANK],
                    wdata_s[`RBSD_BIT_HALF]}; // RULE_13
    end
  end

  // Read path: only the switch buffer is readable here
  wire switch_read = sel_switch && wr_n_s;
  always @(posedge clk_sys) begin
    if (!rstn) begin
      host_rdata <= 8'h00;
    end else if (switch_read) begin
      host_rdata <= sw_s; // RULE_11
    end
  end
  assign host_rdata_oe_n = ~switch_read; // RULE_11

  // Seventeen banks: 16 via decoder, the seventeenth in the system ROM
  wire high_bank = bank_copy[1]; // RULE_04 RULE_14
  wire [2:0] ce_index = bank_sel[`RBSD_BIT_CE_HI:`RBSD_BIT_CE_LO]; // RULE_07

  rbsd_ce_decoder u_ce (
    .enable(~high_bank), // RULE_04
    .sel(ce_index),
    .ce_n(rom_chip_enables)
  );

  assign diag_leds_n = rom_chip_enables; // RULE_15
  assign rom_high_addr = bank_copy[0]; // RULE_05 RULE_07

  wire in_window = (addr_s[15:14] == win_base[15:14]) && phi2_s;
  wire in_sys = (addr_s[15:14] == sys_base[15:14]) && phi2_s;

  // Low ROM (banks 0 and 1) selected by window plus enable 0
  assign low_rom_chip_enable = ~(in_window && !rom_chip_enables[0]); // RULE_08
  // Other bank ROMs: window gated by their own enables externally
  assign bank_rom_ce_n = ~(in_window && !high_bank); // RULE_04

  // System ROM device: system half always, bank half when D4 is high
  assign sys_rom_ce_n = ~(in_sys || (in_window && high_bank)); // RULE_01 RULE_02
  assign sys_rom_a14 = addr_s[14]; // RULE_02
endmodule // rbsd_rom_bank_select_decoder
`default_nettype wire

// ### test/rbsd_checker_sva.sv
`timescale 1ns/10ps
`default_nettype none
module rbsd_checker (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [15:0] host_addr,
  input wire logic phi2,
  input wire logic host_wr_n,
  input wire logic bank_strobe_n,
  input wire logic bank_rom_ce_n,
  input wire logic adapter_irq,
  input wire logic service_req_oe_n,
  input wire logic bus_interface_adapter_sel_n,
  input wire logic switch_sel_n,
  input wire logic host_rdata_oe_n,
  input wire logic [7:0] rom_chip_enables,
  input wire logic [7:0] diag_leds_n,
  input wire logic low_rom_chip_enable,
  input wire logic sys_rom_ce_n,
  input wire logic sys_rom_a14
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_leds_copy: assert property (diag_leds_n == rom_chip_enables)
    else $error("indicators differ");
  a_sys_window: assert property (host_addr[15:14] == 2'b11 && phi2
    |-> ##2 !sys_rom_ce_n) else $error("system rom lost");
  a_half_pick: assert property (1'b1
    |-> ##2 sys_rom_a14 == $past(host_addr[14], 2)) else $error("a14");
  a_switch_sel: assert property (host_addr[15:8] == 8'h7c && phi2
    |-> ##2 !switch_sel_n) else $error("switch select");
  a_rd_oe: assert property (!host_rdata_oe_n |-> !switch_sel_n)
    else $error("stray read drive");
  a_adapter_sel: assert property (host_addr[15:8] == 8'h7a && phi2
    |-> ##2 !bus_interface_adapter_sel_n) else $error("adapter select");
  a_io_quiet: assert property (host_addr[15:11] != 5'h0f || !phi2
    |-> ##2 switch_sel_n && bus_interface_adapter_sel_n)
    else $error("io select outside page");
  a_irq_pull: assert property (adapter_irq |-> ##2 !service_req_oe_n)
    else $error("request not pulled");
  a_low_rom: assert property (host_addr[15:14] != 2'b10
    |-> ##2 low_rom_chip_enable) else $error("low rom outside window");
  a_bank_strobe: assert property (host_addr[15:8] == 8'h7e && phi2
    && !host_wr_n |-> ##2 !bank_strobe_n) else $error("bank strobe");
  a_bank_rom: assert property (host_addr[15:14] != 2'b10
    |-> ##2 bank_rom_ce_n) else $error("bank rom outside window");
endmodule // rbsd_checker
bind rbsd_rom_bank_select_decoder rbsd_checker rbsd_checker_inst (
  .clk_sys(clk_sys), .rstn(rstn), .host_addr(host_addr), .phi2(phi2),
  .host_wr_n(host_wr_n), .bank_strobe_n(bank_strobe_n),
  .bank_rom_ce_n(bank_rom_ce_n),
  .adapter_irq(adapter_irq), .service_req_oe_n(service_req_oe_n),
  .bus_interface_adapter_sel_n(bus_interface_adapter_sel_n),
  .switch_sel_n(switch_sel_n), .host_rdata_oe_n(host_rdata_oe_n),
  .rom_chip_enables(rom_chip_enables), .diag_leds_n(diag_leds_n),
  .low_rom_chip_enable(low_rom_chip_enable),
  .sys_rom_ce_n(sys_rom_ce_n), .sys_rom_a14(sys_rom_a14));
`default_nettype wire

// ### test/rbsd_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module rbsd_host_model (
  input wire logic clk_sys,
  input wire logic [7:0] host_rdata,
  output logic [15:0] host_addr,
  output logic [7:0] host_wdata,
  output logic host_wr_n,
  output logic phi2
);
  initial begin
    host_addr = 16'h0000;
    host_wdata = 8'h00;
    host_wr_n = 1'b1;
    phi2 = 1'b0;
  end
  // Address and data outlast the phi2 fall so the latch edge still sees them
  task cyc(input logic [15:0] a, input logic [7:0] d, input logic w,
    output logic [7:0] q);
    @(posedge clk_sys);
    #2;
    host_addr = a;
    host_wdata = d;
    host_wr_n = ~w;
    phi2 = 1'b1;
    repeat (4) @(posedge clk_sys);
    #2;
    q = host_rdata;
    phi2 = 1'b0;
    repeat (3) @(posedge clk_sys);
    #2;
    host_wr_n = 1'b1;
    host_wdata = ~d;
    host_addr = 16'h0000;
  endtask
endmodule // rbsd_host_model
`default_nettype wire

// ### test/rom_bank_select_decoder_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module rom_bank_select_decoder_tb_top;
  logic clk_sys, rstn, adapter_irq, high_addr, srq_o, srq_oe_n, wr_n, phi2;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, switches, ces, q;
  int fail_count = 0;
  int n_tests = 0;
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  rbsd_host_model rbsd_host_model_inst (.clk_sys(clk_sys), .host_rdata(rdata),
    .host_addr(addr), .host_wdata(wdata), .host_wr_n(wr_n), .phi2(phi2));
  rbsd_rom_bank_select_decoder rbsd_rom_bank_select_decoder_inst (
    .clk_sys(clk_sys), .rstn(rstn), .host_addr(addr), .host_wdata(wdata),
    .host_wr_n(wr_n), .phi2(phi2), .host_rdata(rdata), .host_rdata_oe_n(),
    .rear_switches(switches), .adapter_irq(adapter_irq),
    .service_req_o(srq_o), .service_req_oe_n(srq_oe_n),
    .bus_interface_adapter_sel_n(), .switch_sel_n(), .bank_strobe_n(),
    .rom_chip_enables(ces), .diag_leds_n(), .low_rom_chip_enable(),
    .rom_high_addr(high_addr), .sys_rom_ce_n(), .sys_rom_a14(),
    .bank_rom_ce_n());
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task t_banks;
    logic [4:0] b;
    for (int i = 0; i < 17; i++) begin
      b = i[4:0];
      rbsd_host_model_inst.cyc(16'h7e00, {3'h0, b}, 1'b1, q);
      // A write to another I/O address must leave the bank alone
      rbsd_host_model_inst.cyc(16'h7a00, {3'h7, ~b}, 1'b1, q);
      rbsd_host_model_inst.cyc(16'h8000, 8'h00, 1'b0, q);
      rbsd_host_model_inst.cyc(16'hc000, 8'h00, 1'b0, q);
      chk(ces, b[4] ? 8'hff : ~(8'h01 << b[3:1]));
      chk({7'h00, high_addr}, {7'h00, b[0]});
    end
  endtask
  task t_switch;
    switches = 8'ha5;
    rbsd_host_model_inst.cyc(16'h7c00, 8'h00, 1'b0, q);
    chk(q, 8'ha5);
  endtask
  task t_irq;
    adapter_irq = 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({6'h00, srq_o, srq_oe_n}, 8'h00);
    #2;
    adapter_irq = 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({6'h00, srq_o, srq_oe_n}, 8'h01);
  endtask
  initial begin
    rstn = 1'b0;
    adapter_irq = 1'b0;
    switches = 8'h00;
    repeat (16) @(posedge clk_sys);
    #2;
    rstn = 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(ces, 8'hfe);
    t_banks();
    t_switch();
    t_irq();
    finish_test();
  end
endmodule // rom_bank_select_decoder_tb_top
`default_nettype wire
